// file: rtl/burst_sram_device.sv
// Memory end of the link: a burst-of-four separate-I/O static RAM port.
// All link pins are sampled by two flip-flops on clk_sys_i, which must run
// well above the link clock; the controller keeps C in phase with K or holds the C pair high.
`timescale 1ns/1ns
`default_nettype none
module burst_sram_device #(
    parameter int ADDR_W = qdr_port_pkg::ADDR_W_DEF
) (
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    // Link pins.
    sram_link_if.memory link,
    // Burst status.
    output logic rd_busy_o,
    output logic wr_busy_o
);
    import qdr_port_pkg::*;

    localparam int IN_W = 8 + ADDR_W + DATA_W;
    localparam int DEPTH = 1 << (ADDR_W + BEAT_W);

    logic [IN_W-1:0] pin_s1_reg;
    logic [IN_W-1:0] pin_s2_reg;
    logic [3:0] clk_prev_reg;
    logic k_s, kc_s, c_s, cc_s, rreq_n_s, wreq_n_s, up_n_s, lo_n_s;
    logic [ADDR_W-1:0] addr_s;
    logic [DATA_W-1:0] d_s;
    logic k_rise, kc_rise, c_rise, cc_rise;
    logic use_k, out_true_rise, out_comp_rise;
    logic rd_go, wr_go;
    logic rd_last_reg, rd_last_next, wr_last_reg, wr_last_next;
    logic wr_arm_reg, wr_arm_next, wr_busy_reg, wr_busy_next;
    logic [ADDR_W-1:0] wr_arm_addr_reg, wr_arm_addr_next;
    logic [ADDR_W-1:0] wr_base_reg, wr_base_next;
    logic [BEAT_W-1:0] wr_cnt_reg, wr_cnt_next;
    logic mem_we;
    logic [ADDR_W+BEAT_W-1:0] mem_idx;
    logic [DATA_W-1:0] mem_word;
    logic [DATA_W-1:0] mem_reg [DEPTH];
    logic rd_arm_reg, rd_arm_next, rd_busy_reg, rd_busy_next;
    logic [ADDR_W-1:0] rd_arm_addr_reg, rd_arm_addr_next;
    logic [ADDR_W-1:0] rd_base_reg, rd_base_next;
    logic [BEAT_W-1:0] rd_cnt_reg, rd_cnt_next;
    logic [DATA_W-1:0] q_reg, q_next;
    logic q_oe_reg, q_oe_next;
    logic launch;

    // Two-flop synchroniser for every link input; only stage two is read.
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            // Idle pin levels, so no false clock edge follows reset.
            pin_s1_reg <= {8'h5f, {(ADDR_W + DATA_W){1'b0}}};
            pin_s2_reg <= {8'h5f, {(ADDR_W + DATA_W){1'b0}}};
            clk_prev_reg <= 4'h5;
        end
        else
        begin
            pin_s1_reg <= {link.k_true, link.k_comp, link.c_true, link.c_comp,
                           link.rd_req_n, link.wr_req_n, link.upper_nibble_write_n,
                           link.lower_nibble_write_n, link.addr, link.d};
            pin_s2_reg <= pin_s1_reg;
            clk_prev_reg <= pin_s2_reg[IN_W-1:IN_W-4];
        end
    end

    // Unpack the synchronised pins and find the clock rises.
    assign {k_s, kc_s, c_s, cc_s, rreq_n_s, wreq_n_s, up_n_s, lo_n_s,
            addr_s, d_s} = pin_s2_reg;
    assign k_rise = k_s & ~clk_prev_reg[3];
    assign kc_rise = kc_s & ~clk_prev_reg[2];
    assign c_rise = c_s & ~clk_prev_reg[1];
    assign cc_rise = cc_s & ~clk_prev_reg[0];
    assign use_k = c_s & cc_s;
    assign out_true_rise = use_k ? k_rise : c_rise;
    assign out_comp_rise = use_k ? kc_rise : cc_rise;

    // Request decode: strobes count only at a true K rise.
    assign rd_go = k_rise & ~rreq_n_s & ~rd_last_reg;
    assign wr_go = k_rise & ~wreq_n_s & ~wr_last_reg & ~rd_go;

    always_comb
    begin
        rd_last_next = k_rise ? rd_go : rd_last_reg;
        wr_last_next = k_rise ? wr_go : wr_last_reg;
    end

    // Write burst: armed at the issuing rise, beats on the following rises.
    always_comb
    begin
        wr_arm_next = wr_arm_reg;
        wr_arm_addr_next = wr_arm_addr_reg;
        wr_busy_next = wr_busy_reg;
        wr_base_next = wr_base_reg;
        wr_cnt_next = wr_cnt_reg;
        mem_we = 1'b0;
        mem_idx = {wr_base_reg, wr_cnt_reg};
        if (k_rise)
        begin
            if (wr_arm_reg)
            begin
                mem_we = 1'b1;
                mem_idx = {wr_arm_addr_reg, {BEAT_W{1'b0}}};
                wr_base_next = wr_arm_addr_reg;
                wr_busy_next = 1'b1;
                wr_cnt_next = 2'h1;
            end
            else if (wr_busy_reg && wr_cnt_reg == THIRD_BEAT)
            begin
                mem_we = 1'b1;
                wr_cnt_next = LAST_BEAT;
            end
            wr_arm_next = wr_go;
            if (wr_go)
            begin
                wr_arm_addr_next = addr_s;
            end
        end
        if (kc_rise && wr_busy_reg && wr_cnt_reg[0])
        begin
            mem_we = 1'b1;
            wr_cnt_next = wr_cnt_reg + 2'h1;
            if (wr_cnt_reg == LAST_BEAT)
            begin
                wr_busy_next = 1'b0;
            end
        end
    end

    // Nibble merge: a high enable keeps the stored nibble.
    always_comb
    begin
        mem_word = mem_reg[mem_idx];
        if (!lo_n_s)
        begin
            mem_word[NIB_W-1:0] = d_s[NIB_W-1:0];
        end
        if (!up_n_s)
        begin
            mem_word[DATA_W-1:NIB_W] = d_s[DATA_W-1:NIB_W];
        end
    end

    // Storage array, written one beat at a time.
    always_ff @(posedge clk_sys_i)
    begin
        if (mem_we)
        begin
            mem_reg[mem_idx] <= mem_word;
        end
    end

    // Read burst: the two output rises after the issue are skipped, then beats
    // go out on complement, true, complement, true rises.
    always_comb
    begin
        rd_arm_next = rd_arm_reg;
        rd_arm_addr_next = rd_arm_addr_reg;
        rd_busy_next = rd_busy_reg;
        rd_base_next = rd_base_reg;
        rd_cnt_next = rd_cnt_reg;
        q_next = q_reg;
        q_oe_next = q_oe_reg;
        launch = rd_busy_reg && ((out_comp_rise && !rd_cnt_reg[0]) ||
                                 (out_true_rise && rd_cnt_reg[0]));
        if (launch)
        begin
            q_next = mem_reg[{rd_base_reg, rd_cnt_reg}];
            q_oe_next = 1'b1;
            rd_cnt_next = rd_cnt_reg + 2'h1;
        end
        else if (out_true_rise || out_comp_rise)
        begin
            q_oe_next = 1'b0;
        end
        if (out_true_rise)
        begin
            if (rd_arm_reg)
            begin
                rd_arm_next = 1'b0;
                rd_busy_next = 1'b1;
                rd_base_next = rd_arm_addr_reg;
                rd_cnt_next = '0;
            end
            else if (rd_busy_reg && rd_cnt_reg == LAST_BEAT)
            begin
                rd_busy_next = 1'b0;
            end
        end
        if (rd_go)
        begin
            rd_arm_next = 1'b1;
            rd_arm_addr_next = addr_s;
        end
    end

    // Control state; outputs float from reset until the first read.
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rd_last_reg <= 1'b0;
            wr_last_reg <= 1'b0;
            wr_arm_reg <= 1'b0;
            wr_arm_addr_reg <= '0;
            wr_busy_reg <= 1'b0;
            wr_base_reg <= '0;
            wr_cnt_reg <= '0;
            rd_arm_reg <= 1'b0;
            rd_arm_addr_reg <= '0;
            rd_busy_reg <= 1'b0;
            rd_base_reg <= '0;
            rd_cnt_reg <= '0;
            q_reg <= '0;
            q_oe_reg <= 1'b0;
        end
        else
        begin
            rd_last_reg <= rd_last_next;
            wr_last_reg <= wr_last_next;
            wr_arm_reg <= wr_arm_next;
            wr_arm_addr_reg <= wr_arm_addr_next;
            wr_busy_reg <= wr_busy_next;
            wr_base_reg <= wr_base_next;
            wr_cnt_reg <= wr_cnt_next;
            rd_arm_reg <= rd_arm_next;
            rd_arm_addr_reg <= rd_arm_addr_next;
            rd_busy_reg <= rd_busy_next;
            rd_base_reg <= rd_base_next;
            rd_cnt_reg <= rd_cnt_next;
            q_reg <= q_next;
            q_oe_reg <= q_oe_next;
        end
    end

    // Outputs straight from flip-flops.
    assign link.q = q_reg;
    assign link.q_oe = q_oe_reg;
    assign rd_busy_o = rd_busy_reg;
    assign wr_busy_o = wr_busy_reg;
endmodule
`default_nettype wire

// file: rtl/qdr_port_pkg.sv
// Shared constants for the burst-of-four static RAM port and its controller.
// Assumes one system clock; the link clocks are made from it by a divider.
package qdr_port_pkg;
    // System clock and link clock timing.
    localparam int SYS_PERIOD_NS = 10;
    localparam int K_PERIOD_NS = 80;
    localparam int K_PERIOD_CYC = K_PERIOD_NS / SYS_PERIOD_NS;
    localparam int PH_W = $clog2(K_PERIOD_CYC);
    localparam logic [PH_W-1:0] K_HALF = PH_W'(K_PERIOD_CYC / 2);
    localparam logic [PH_W-1:0] TRUE_RISE_PH = '0;
    // Lines change two cycles ahead of the clock rise that samples them.
    localparam logic [PH_W-1:0] ISSUE_PH = PH_W'(K_PERIOD_CYC - 2);
    localparam logic [PH_W-1:0] COMP_DRIVE_PH = PH_W'(K_PERIOD_CYC / 2 - 2);
    localparam logic [PH_W-1:0] PH_RESET = PH_W'(K_PERIOD_CYC - 1);
    // Data path layout.
    localparam int DATA_W = 8;
    localparam int NIB_W = 4;
    localparam int BURST_LEN = 4;
    localparam int BEAT_W = 2;
    localparam int ADDR_W_DEF = 4;
    localparam int WORDS_W = BURST_LEN * DATA_W;
    localparam int MASK_W = 2 * BURST_LEN;
    localparam logic [BEAT_W-1:0] LAST_BEAT = BEAT_W'(BURST_LEN - 1);
    localparam logic [BEAT_W-1:0] THIRD_BEAT = 2'h2;
    // Output clock rise to read capture: two syncs each way plus launch.
    localparam int CAPTURE_DELAY = 6;
    localparam int BUF_DEPTH = 2;
endpackage

// file: rtl/sram_link_if.sv
// Pin bundle between the memory controller and the burst static RAM port.
// Q is tri-state: q_oe high means the memory drives q.
`timescale 1ns/1ns
`default_nettype none
interface sram_link_if #(parameter int ADDR_W = qdr_port_pkg::ADDR_W_DEF);
    logic k_true;
    logic k_comp;
    logic c_true;
    logic c_comp;
    logic rd_req_n;
    logic wr_req_n;
    logic [ADDR_W-1:0] addr;
    logic [qdr_port_pkg::DATA_W-1:0] d;
    logic lower_nibble_write_n;
    logic upper_nibble_write_n;
    logic [qdr_port_pkg::DATA_W-1:0] q;
    logic q_oe;

    // Memory end.
    modport memory (
        input k_true, k_comp, c_true, c_comp, rd_req_n, wr_req_n, addr, d,
        input lower_nibble_write_n, upper_nibble_write_n,
        output q, q_oe
    );

    // Controller end.
    modport controller (
        output k_true, k_comp, c_true, c_comp, rd_req_n, wr_req_n, addr, d,
        output lower_nibble_write_n, upper_nibble_write_n,
        input q, q_oe
    );
endinterface
`default_nettype wire

// file: rtl/burst_sram_controller.sv
// Controller end of the link: makes the K and C clock pairs by dividing
// clk_sys_i, issues queued burst commands and returns read words.
// Assumes the memory end samples its pins on the same clk_sys_i.
`timescale 1ns/1ns
`default_nettype none
module burst_sram_controller #(
    parameter int ADDR_W = qdr_port_pkg::ADDR_W_DEF
) (
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    // Link pins.
    sram_link_if.controller link,
    // Command queue input.
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    input wire logic cmd_write_i,
    input wire logic [ADDR_W-1:0] cmd_addr_i,
    input wire logic [qdr_port_pkg::WORDS_W-1:0] cmd_wdata_i,
    input wire logic [qdr_port_pkg::MASK_W-1:0] cmd_nw_mask_i,
    // Mode: hold C pair high so reads follow the K pair.
    input wire logic k_mode_i,
    // Read data out.
    output logic [qdr_port_pkg::DATA_W-1:0] rd_data_o,
    output logic rd_valid_o
);
    import qdr_port_pkg::*;

    localparam int CMD_W = 1 + ADDR_W + WORDS_W + MASK_W;

    logic [CMD_W-1:0] buf_reg [BUF_DEPTH];
    logic wp_reg, wp_next, rp_reg, rp_next, ready_reg, ready_next;
    logic [1:0] cnt_reg, cnt_next;
    logic push, issue, head_wr;
    logic [CMD_W-1:0] head;
    logic [PH_W-1:0] ph_reg, ph_next;
    logic k_reg, k_next, kc_reg, kc_next, c_reg, c_next, cc_reg, cc_next;
    logic mode_reg, mode_next;
    logic rn_reg, rn_next, wn_reg, wn_next, rl_reg, rl_next, wl_reg, wl_next;
    logic [ADDR_W-1:0] addr_reg, addr_next;
    logic pv_reg, pv_next, act_reg, act_next;
    logic [WORDS_W+MASK_W-1:0] pend_reg, pend_next, sh_reg, sh_next;
    logic [BEAT_W-1:0] bc_reg, bc_next;
    logic [DATA_W-1:0] d_reg, d_next;
    logic [1:0] nw_reg, nw_next;
    logic [DATA_W:0] qs1_reg, qs2_reg;
    logic [CAPTURE_DELAY-1:0] evt_reg, evt_next;
    logic [DATA_W-1:0] rdat_reg, rdat_next;
    logic rv_reg, rv_next;

    assign head = buf_reg[rp_reg];
    assign head_wr = head[CMD_W-1];
    assign push = cmd_valid_i & ready_reg;

    // Sequencer, clock divider, queue pointers and read capture.
    always_comb
    begin
        ph_next = ph_reg + 1'b1;
        k_next = ph_next < K_HALF;
        kc_next = ~k_next;
        // Mode changes only at a true K rise, so C never rises apart from K.
        mode_next = (ph_next == TRUE_RISE_PH) ? k_mode_i : mode_reg;
        c_next = mode_next | k_next;
        cc_next = mode_next | kc_next;
        issue = ph_next == ISSUE_PH && cnt_reg != 2'h0 &&
                (head_wr ? ~wl_reg : ~rl_reg);
        rn_next = rn_reg;
        wn_next = wn_reg;
        rl_next = rl_reg;
        wl_next = wl_reg;
        addr_next = addr_reg;
        pv_next = pv_reg;
        pend_next = pend_reg;
        act_next = act_reg;
        sh_next = sh_reg;
        bc_next = bc_reg;
        d_next = d_reg;
        nw_next = nw_reg;
        if (ph_next == ISSUE_PH)
        begin
            rn_next = ~(issue & ~head_wr);
            wn_next = ~(issue & head_wr);
            rl_next = issue & ~head_wr;
            wl_next = issue & head_wr;
            if (issue)
            begin
                addr_next = head[CMD_W-2 -: ADDR_W];
            end
            if (pv_reg)
            begin
                sh_next = pend_reg;
                act_next = 1'b1;
                bc_next = 2'h1;
                d_next = pend_reg[MASK_W +: DATA_W];
                nw_next = pend_reg[1:0];
            end
            else if (act_reg && bc_reg == THIRD_BEAT)
            begin
                d_next = sh_reg[MASK_W + DATA_W * bc_reg +: DATA_W];
                nw_next = sh_reg[2 * bc_reg +: 2];
                bc_next = LAST_BEAT;
            end
            pv_next = issue & head_wr;
            pend_next = head[WORDS_W+MASK_W-1:0];
        end
        else if (ph_next == COMP_DRIVE_PH)
        begin
            rn_next = 1'b1;
            wn_next = 1'b1;
            if (act_reg)
            begin
                d_next = sh_reg[MASK_W + DATA_W * bc_reg +: DATA_W];
                nw_next = sh_reg[2 * bc_reg +: 2];
                bc_next = bc_reg + 2'h1;
                act_next = bc_reg != LAST_BEAT;
            end
        end
        cnt_next = cnt_reg + {1'b0, push} - {1'b0, issue};
        ready_next = cnt_next < 2'(BUF_DEPTH);
        wp_next = wp_reg ^ push;
        rp_next = rp_reg ^ issue;
        evt_next = {evt_reg[CAPTURE_DELAY-2:0],
                    ph_next == TRUE_RISE_PH || ph_next == K_HALF};
        rv_next = evt_reg[CAPTURE_DELAY-1] & qs2_reg[DATA_W];
        rdat_next = rv_next ? qs2_reg[DATA_W-1:0] : rdat_reg;
    end

    // Two-entry command store, filled at the write pointer.
    always_ff @(posedge clk_sys_i)
    begin
        if (push)
        begin
            buf_reg[wp_reg] <= {cmd_write_i, cmd_addr_i, cmd_wdata_i, cmd_nw_mask_i};
        end
    end

    // State registers; returned data passes two flip-flops first.
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            ph_reg <= PH_RESET;
            {k_reg, kc_reg, c_reg, cc_reg} <= 4'h5;
            mode_reg <= 1'b0;
            {rn_reg, wn_reg, rl_reg, wl_reg} <= 4'hc;
            addr_reg <= '0;
            {pv_reg, act_reg, bc_reg} <= '0;
            pend_reg <= '0;
            sh_reg <= '0;
            d_reg <= '0;
            nw_reg <= 2'h3;
            {wp_reg, rp_reg, cnt_reg, ready_reg} <= 5'h01;
            qs1_reg <= '0;
            qs2_reg <= '0;
            evt_reg <= '0;
            rdat_reg <= '0;
            rv_reg <= 1'b0;
        end
        else
        begin
            ph_reg <= ph_next;
            {k_reg, kc_reg, c_reg, cc_reg} <= {k_next, kc_next, c_next, cc_next};
            mode_reg <= mode_next;
            {rn_reg, wn_reg, rl_reg, wl_reg} <= {rn_next, wn_next, rl_next, wl_next};
            addr_reg <= addr_next;
            {pv_reg, act_reg, bc_reg} <= {pv_next, act_next, bc_next};
            pend_reg <= pend_next;
            sh_reg <= sh_next;
            d_reg <= d_next;
            nw_reg <= nw_next;
            {wp_reg, rp_reg, cnt_reg, ready_reg} <= {wp_next, rp_next, cnt_next, ready_next};
            qs1_reg <= {link.q_oe, link.q};
            qs2_reg <= qs1_reg;
            evt_reg <= evt_next;
            rdat_reg <= rdat_next;
            rv_reg <= rv_next;
        end
    end

    // Pins and user outputs straight from flip-flops.
    assign link.k_true = k_reg;
    assign link.k_comp = kc_reg;
    assign link.c_true = c_reg;
    assign link.c_comp = cc_reg;
    assign link.rd_req_n = rn_reg;
    assign link.wr_req_n = wn_reg;
    assign link.addr = addr_reg;
    assign link.d = d_reg;
    assign link.lower_nibble_write_n = nw_reg[0];
    assign link.upper_nibble_write_n = nw_reg[1];
    assign cmd_ready_o = ready_reg;
    assign rd_data_o = rdat_reg;
    assign rd_valid_o = rv_reg;
endmodule
`default_nettype wire

// file: verif/burst_sram_port_chk.sv
// Checker for the link between the burst static RAM port and its controller.
// Assumes one clock, link pins sampled on clk_sys_i, K period of 8 cycles.
`timescale 1ns/1ns
`default_nettype none
module burst_sram_port_chk #(
    parameter int ADDR_W = qdr_port_pkg::ADDR_W_DEF
) (
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    // Link pins.
    input wire logic k_true,
    input wire logic k_comp,
    input wire logic c_true,
    input wire logic c_comp,
    input wire logic rd_req_n,
    input wire logic wr_req_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [qdr_port_pkg::DATA_W-1:0] d,
    input wire logic lower_nibble_write_n,
    input wire logic upper_nibble_write_n,
    input wire logic [qdr_port_pkg::DATA_W-1:0] q,
    input wire logic q_oe
);
    import qdr_port_pkg::*;
    logic k_prev_reg;
    logic [5:0] since_rd_reg;
    logic [5:0] since_rd_next;
    logic [5:0] since_wr_reg;
    logic [5:0] since_wr_next;
    logic [5:0] prev_wr_reg;
    logic [5:0] prev_wr_next;

    // Cycles since the last read and the last two writes seen at K rises, saturating.
    always_comb
    begin
        since_rd_next = (since_rd_reg == 6'h3f) ? since_rd_reg : since_rd_reg + 6'h01;
        since_wr_next = (since_wr_reg == 6'h3f) ? since_wr_reg : since_wr_reg + 6'h01;
        prev_wr_next = (prev_wr_reg == 6'h3f) ? prev_wr_reg : prev_wr_reg + 6'h01;
        if (k_true && !k_prev_reg && !rd_req_n)
            since_rd_next = 6'h00;
        else if (k_true && !k_prev_reg && !wr_req_n)
        begin
            prev_wr_next = since_wr_next;
            since_wr_next = 6'h00;
        end
    end

    // Counters start saturated, so no read counts as pending after reset.
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            k_prev_reg <= 1'b0;
            since_rd_reg <= 6'h3f;
            since_wr_reg <= 6'h3f;
            prev_wr_reg <= 6'h3f;
        end
        else
        begin
            k_prev_reg <= k_true;
            since_rd_reg <= since_rd_next;
            since_wr_reg <= since_wr_next;
            prev_wr_reg <= prev_wr_next;
        end
    end

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_b_i);

    chk_k_pair_phase: assert property ($rose(k_true) |-> $fell(k_comp) ##4 $rose(k_comp))
        else $error("K pair is not complementary");
    chk_strobe_before_k: assert property (($fell(rd_req_n) || $fell(wr_req_n))
        |-> !k_true ##2 $rose(k_true))
        else $error("Request strobe not set up for the true K rise");
    chk_rd_not_repeated: assert property ($rose(k_true) && !rd_req_n |-> ##8 rd_req_n)
        else $error("Read requested on consecutive K rises");
    chk_wr_not_repeated: assert property ($rose(k_true) && !wr_req_n |-> ##8 wr_req_n)
        else $error("Write requested on consecutive K rises");
    chk_q_idle_float: assert property (q_oe |-> since_rd_reg <= 6'd40)
        else $error("Data outputs driven with no read in flight");
    chk_rd_launch_time: assert property ($rose(q_oe) |-> since_rd_reg inside {[6'd10:6'd20]})
        else $error("Read data launched at the wrong time");
    chk_nibble_beat_window: assert property (($fell(lower_nibble_write_n)
        || $fell(upper_nibble_write_n)) |-> since_wr_reg inside {[6'd4:6'd20]}
        || prev_wr_reg inside {[6'd4:6'd20]})
        else $error("Nibble enable outside write beats");
    chk_c_with_k: assert property ($rose(c_true) |-> k_true)
        else $error("Output clock rise not aligned to K");
endmodule
`default_nettype wire

// file: verif/quad_rate_burst4_sram_port_test.sv
// Testbench joining controller and memory end through the link interface.
// Assumes a 100 MHz clock and the command port handshake of the controller.
`timescale 1ns/1ns
`default_nettype none
module quad_rate_burst4_sram_port_test;
    import qdr_port_pkg::*;
    localparam int ADDR_W = ADDR_W_DEF;
    logic clk_sys_i;
    logic rst_b_i;
    logic cmd_valid_i;
    logic cmd_ready_o;
    logic cmd_write_i;
    logic [ADDR_W-1:0] cmd_addr_i;
    logic [WORDS_W-1:0] cmd_wdata_i;
    logic [MASK_W-1:0] cmd_nw_mask_i;
    logic k_mode_i;
    logic [DATA_W-1:0] rd_data_o;
    logic rd_valid_o;
    logic rd_busy_o;
    logic wr_busy_o;
    logic [DATA_W-1:0] model [0:(1<<ADDR_W)*BURST_LEN-1];
    logic [DATA_W-1:0] exp_q[$];
    logic [DATA_W-1:0] got_q[$];
    int mismatches;
    int checks;
    int rd_links;
    int wr_links;
    int rd_cmds;
    int wr_cmds;

    sram_link_if #(.ADDR_W(ADDR_W)) link ();

    burst_sram_device #(.ADDR_W(ADDR_W)) i_burst_sram_device (.clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i), .link(link), .rd_busy_o(rd_busy_o), .wr_busy_o(wr_busy_o));

    burst_sram_controller #(.ADDR_W(ADDR_W)) i_burst_sram_controller (.clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i), .link(link), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
        .cmd_write_i(cmd_write_i), .cmd_addr_i(cmd_addr_i), .cmd_wdata_i(cmd_wdata_i),
        .cmd_nw_mask_i(cmd_nw_mask_i), .k_mode_i(k_mode_i), .rd_data_o(rd_data_o),
        .rd_valid_o(rd_valid_o));

    burst_sram_port_chk #(.ADDR_W(ADDR_W)) i_burst_sram_port_chk (.clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i), .k_true(link.k_true), .k_comp(link.k_comp), .c_true(link.c_true),
        .c_comp(link.c_comp), .rd_req_n(link.rd_req_n), .wr_req_n(link.wr_req_n),
        .addr(link.addr), .d(link.d), .lower_nibble_write_n(link.lower_nibble_write_n),
        .upper_nibble_write_n(link.upper_nibble_write_n), .q(link.q), .q_oe(link.q_oe));

    // Free-running system clock.
    initial clk_sys_i = 1'b0;
    always #5 clk_sys_i = ~clk_sys_i;

    // Collect read bytes and count requests seen on the wire at K rises.
    always @(posedge clk_sys_i)
        if (rd_valid_o === 1'b1) got_q.push_back(rd_data_o);
    always @(posedge link.k_true)
    begin
        if (link.rd_req_n === 1'b0) rd_links++;
        else if (link.wr_req_n === 1'b0) wr_links++;
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish();
        $display("Counts: %0d checks, %0d mismatches", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Compares one value and reports a mismatch at once.
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Offers one command, holds it until taken, and updates the expected image.
    task automatic send(input logic wr, input logic [ADDR_W-1:0] a,
        input logic [WORDS_W-1:0] w, input logic [MASK_W-1:0] m);
        int n;
        int idx;
        n = 0;
        cmd_valid_i <= 1'b1;
        cmd_write_i <= wr;
        cmd_addr_i <= a;
        cmd_wdata_i <= w;
        cmd_nw_mask_i <= m;
        do
        begin
            @(posedge clk_sys_i);
            n++;
        end while (cmd_ready_o !== 1'b1 && n < 200);
        cmd_valid_i <= 1'b0;
        if (n >= 200)
        begin
            mismatches++;
            tally_and_finish();
        end
        for (int i = 0; i < BURST_LEN; i++)
        begin
            idx = int'(a) * BURST_LEN + i;
            if (wr && !m[2*i]) model[idx][3:0] = w[i*8 +: 4];
            if (wr && !m[2*i+1]) model[idx][7:4] = w[i*8+4 +: 4];
            if (!wr) exp_q.push_back(model[idx]);
        end
        if (wr) wr_cmds++;
        else rd_cmds++;
        @(posedge clk_sys_i);
    endtask

    // Waits for all read bytes and idle link, then compares everything.
    task automatic drain(input string name);
        int n;
        n = 0;
        while ((got_q.size() < exp_q.size() || link.q_oe !== 1'b0 || rd_busy_o !== 1'b0
            || wr_busy_o !== 1'b0) && n < 600)
        begin
            @(posedge clk_sys_i);
            n++;
        end
        if (n >= 600)
        begin
            mismatches++;
            tally_and_finish();
        end
        while (exp_q.size() > 0)
            check(32'(got_q.pop_front()), 32'(exp_q.pop_front()));
        check(32'(got_q.size()), 32'h0);
        check(32'(rd_links), 32'(rd_cmds));
        check(32'(wr_links), 32'(wr_cmds));
        check(32'(link.q_oe), 32'h0);
        $display("Test %s done", name);
    endtask

    initial
    begin
        rst_b_i = 1'b0;
        cmd_valid_i = 1'b0;
        cmd_write_i = 1'b0;
        cmd_addr_i = '0;
        cmd_wdata_i = '0;
        cmd_nw_mask_i = '1;
        k_mode_i = 1'b0;
        repeat (3) @(posedge clk_sys_i);
        check(32'(link.q_oe), 32'h0);
        rst_b_i <= 1'b1;
        repeat (16) @(posedge clk_sys_i);
        check(32'(link.q_oe), 32'h0);
        $display("Test power_up done");
        // Full bursts back to back, then read them back back to back.
        for (int a = 0; a < 4; a++)
            send(1'b1, ADDR_W'(a), 32'(a) * 32'h04040404 + 32'h83828180, 8'h00);
        for (int a = 0; a < 4; a++)
            send(1'b0, ADDR_W'(a), '0, '1);
        drain("fill");
        // Each write covers all four nibble enable combinations, one per beat position.
        send(1'b1, ADDR_W'(1), 32'h3c5a7e96, 8'hd8);
        send(1'b1, ADDR_W'(2), 32'he1d2c3b4, 8'h27);
        send(1'b0, ADDR_W'(1), '0, '1);
        send(1'b0, ADDR_W'(2), '0, '1);
        drain("nibble");
        // Read right after a write to the same burst.
        send(1'b1, ADDR_W'(3), 32'h0f1e2d4b, 8'h00);
        send(1'b0, ADDR_W'(3), '0, '1);
        drain("read_after_write");
        // Output clocks held high: data follows the K pair.
        k_mode_i <= 1'b1;
        repeat (16) @(posedge clk_sys_i);
        check(32'({link.c_true, link.c_comp}), 32'h3);
        for (int a = 0; a < 4; a++)
            send(1'b0, ADDR_W'(a), '0, '1);
        drain("k_mode");
        k_mode_i <= 1'b0;
        repeat (16) @(posedge clk_sys_i);
        tally_and_finish();
    end
endmodule
`default_nettype wire
